// file: rtl/gate_detect_params.svh
// constants for the analog gate trigger detector: offsets, fields, resets, codes
`ifndef GATE_DETECT_PARAMS_SVH
`define GATE_DETECT_PARAMS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_TRIGGER_OR_MASK 16'h9dda
`define IDX_TRIGGER_AND_MASK 16'h9dee
`define IDX_MAIN_EXT_TRIGGER_MODE 16'h9e3e
`define IDX_CHAN_ZERO_TRIGGER_MODE 16'h9ea2
`define IDX_CHAN_ZERO_THRESHOLD 16'ha4d8
`define IDX_MAIN_EXT_THRESHOLD 16'ha550
`define IDX_CHAN_ZERO_PULSE_COUNT 16'hac45
`define IDX_GATE_STATUS 16'hac80

// ----------------------------------------------------------------------
// bus widths
// ----------------------------------------------------------------------
`define ADR_W 18
`define SAMPLE_W 16

// ----------------------------------------------------------------------
// mask bits
// ----------------------------------------------------------------------
`define MAIN_EXT_MASK_BIT 32'h0000_0002
`define CHAN_ZERO_MASK_BIT 32'h0000_0001

// ----------------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------------
`define RISING_MODE_CODE 32'h0000_0001
`define FALLING_MODE_CODE 32'h0000_0002
`define ABOVE_LEVEL_MODE_CODE 32'h0000_0008
`define BELOW_LEVEL_MODE_CODE 32'h0000_0010
`define LONG_PULSE_FLAG 32'h0400_0000
`define LONG_RISING_PULSE_CODE 32'h0400_0001
`define LONG_FALLING_PULSE_CODE 32'h0400_0002

// ----------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------
`define RST_MASK 32'h0000_0000
`define RST_MODE 32'h0000_0000
`define RST_THRESHOLD 32'h0000_0000
`define RST_PULSE_COUNT 32'h0000_0002
`define MIN_PULSE_COUNT 32'h0000_0002

`endif

// file: rtl/gate_detect_pkg.sv
// types shared by the analog gate trigger detector
package gate_detect_pkg;

    // detector states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CLOSED = 4'b0010,
        ST_COUNT = 4'b0100,
        ST_OPEN = 4'b1000
    } det_state_e;

    // decoded trigger mode
    typedef enum logic [2:0] {
        MD_OFF = 3'h0,
        MD_RISE = 3'h1,
        MD_FALL = 3'h2,
        MD_HIGH = 3'h3,
        MD_LOW = 3'h4,
        MD_LONG_POS = 3'h5,
        MD_LONG_NEG = 3'h6
    } det_mode_e;

endpackage

// file: rtl/analog_gate_trigger_detector.sv
// gate detector: threshold crossing, level and pulse-width modes behind wishbone
//
// Behaviour
// R1: an input gates only if its bit is set in the or or and mask
// R2: single-threshold modes exist on both inputs; two-threshold ones only on main
// R3: each sample is compared with the threshold while the board runs
// R4: rising mode code 1h opens the gate on a rising crossing
// R5: rising mode closes the open gate on a falling crossing
// R6: rising mode ignores a signal already high at start
// R7: falling mode code 2h opens the gate on a falling crossing
// R8: falling mode closes the open gate on a rising crossing
// R9: falling mode ignores a signal already low at start
// R10: high level mode 8h is open while sample >= threshold
// R11: level modes open at once if the level holds at start
// R12: low level mode 10h is open while sample <= threshold
// R13: software writes thresholds in millivolts
// R14: long positive pulse opens after the count with no falling crossing
// R15: an opposite crossing before the count cancels detection
// R16: long positive pulse closes on the next falling crossing
// R17: long negative pulse opens after count from falling crossing, closes on rising
// R18: pulse count accepts 2 up to 4G-1 only
// R19: counter steps once per sample; crossings compare previous and current sample
// R20: edge modes open only on events seen after start
`timescale 1ns/1ps
`include "gate_detect_params.svh"

// ----------------------------------------------------------------------
// one detector for one trigger input
// ----------------------------------------------------------------------
module gate_source_detector (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic board_run,
    input wire logic sample_en,
    input wire logic signed [`SAMPLE_W-1:0] sample,
    input wire logic [31:0] mode,
    input wire logic [31:0] threshold,
    input wire logic [31:0] pulse_count,
    output logic gate
);
    gate_detect_pkg::det_state_e state_reg;
    gate_detect_pkg::det_state_e state_next;
    gate_detect_pkg::det_mode_e md;
    logic [31:0] cnt_reg;
    logic prev_above_reg;
    logic signed [31:0] sample_wide;
    logic above;
    logic at_or_below;
    logic rise;
    logic fall;
    logic open_evt;
    logic close_evt;
    logic cnt_done;

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    // unknown codes leave the source closed rather than guessing a mode
    always_comb begin
        unique case (mode) // [R2]
            `RISING_MODE_CODE: md = gate_detect_pkg::MD_RISE;
            `FALLING_MODE_CODE: md = gate_detect_pkg::MD_FALL;
            `ABOVE_LEVEL_MODE_CODE: md = gate_detect_pkg::MD_HIGH;
            `BELOW_LEVEL_MODE_CODE: md = gate_detect_pkg::MD_LOW;
            `LONG_RISING_PULSE_CODE: md = gate_detect_pkg::MD_LONG_POS;
            `LONG_FALLING_PULSE_CODE: md = gate_detect_pkg::MD_LONG_NEG;
            default: md = gate_detect_pkg::MD_OFF;
        endcase
    end

    // ------------------------------------------------------------------
    // comparison and crossings
    // ------------------------------------------------------------------
    // sample and threshold share the millivolt scale
    assign sample_wide = 32'(sample);
    assign above = sample_wide >= $signed(threshold); // [R3] [R13]
    assign at_or_below = sample_wide <= $signed(threshold);
    // crossings need a previous sample, so the first sample after start gives none
    assign rise = (state_reg != gate_detect_pkg::ST_IDLE) && !prev_above_reg && above; // [R19]
    assign fall = (state_reg != gate_detect_pkg::ST_IDLE) && prev_above_reg && !above; // [R19]
    assign cnt_done = (cnt_reg + 32'h1) >= pulse_count;

    always_comb begin
        open_evt = 1'b0;
        close_evt = 1'b0;
        unique case (md)
            gate_detect_pkg::MD_RISE: begin
                open_evt = rise; // [R4] [R6] [R20]
                close_evt = fall; // [R5]
            end
            gate_detect_pkg::MD_FALL: begin
                open_evt = fall; // [R7] [R9] [R20]
                close_evt = rise; // [R8]
            end
            gate_detect_pkg::MD_HIGH: begin
                open_evt = above; // [R10] [R11]
                close_evt = !above; // [R10]
            end
            gate_detect_pkg::MD_LOW: begin
                open_evt = at_or_below; // [R12] [R11]
                close_evt = !at_or_below; // [R12]
            end
            gate_detect_pkg::MD_LONG_POS: begin
                open_evt = rise; // [R14]
                close_evt = fall; // [R16] [R15]
            end
            gate_detect_pkg::MD_LONG_NEG: begin
                open_evt = fall; // [R17]
                close_evt = rise; // [R17] [R15]
            end
            gate_detect_pkg::MD_OFF: begin
                open_evt = 1'b0;
                close_evt = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            gate_detect_pkg::ST_IDLE: begin
                // first sample after start only primes the history,
                // but a level already present opens the gate at once
                if (board_run && sample_en) begin
                    if ((md == gate_detect_pkg::MD_HIGH && above) ||
                        (md == gate_detect_pkg::MD_LOW && at_or_below)) begin // [R11]
                        state_next = gate_detect_pkg::ST_OPEN;
                    end else begin
                        state_next = gate_detect_pkg::ST_CLOSED; // [R6] [R9] [R20]
                    end
                end
            end
            gate_detect_pkg::ST_CLOSED: begin
                if (sample_en && open_evt) begin
                    if (md == gate_detect_pkg::MD_LONG_POS ||
                        md == gate_detect_pkg::MD_LONG_NEG) begin
                        state_next = gate_detect_pkg::ST_COUNT; // [R14] [R17]
                    end else begin
                        state_next = gate_detect_pkg::ST_OPEN;
                    end
                end
            end
            gate_detect_pkg::ST_COUNT: begin
                if (sample_en) begin
                    if (close_evt) begin
                        state_next = gate_detect_pkg::ST_CLOSED; // [R15]
                    end else if (cnt_done) begin
                        state_next = gate_detect_pkg::ST_OPEN; // [R14] [R17]
                    end
                end
            end
            gate_detect_pkg::ST_OPEN: begin
                if (sample_en && close_evt) begin
                    state_next = gate_detect_pkg::ST_CLOSED; // [R5] [R8] [R16] [R17]
                end
            end
            default: state_next = gate_detect_pkg::ST_IDLE;
        endcase
        if (!board_run) begin
            state_next = gate_detect_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= gate_detect_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // sample history and pulse counter
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prev_above_reg <= 1'b0;
        end else if (board_run && sample_en) begin
            prev_above_reg <= above; // [R19]
        end
    end

    // the sample of the crossing counts as the first of the pulse
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_reg <= 32'h0;
        end else if (sample_en) begin
            if (state_reg == gate_detect_pkg::ST_CLOSED) begin
                cnt_reg <= 32'h1;
            end else if (state_reg == gate_detect_pkg::ST_COUNT) begin
                cnt_reg <= cnt_reg + 32'h1; // [R19]
            end
        end
    end

    assign gate = (state_reg == gate_detect_pkg::ST_OPEN);

endmodule // gate_source_detector

// ----------------------------------------------------------------------
// top: registers, two sources, mask combination
// ----------------------------------------------------------------------
module analog_gate_trigger_detector (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic board_run,
    input wire logic sample_en,
    input wire logic signed [`SAMPLE_W-1:0] main_ext_sample,
    input wire logic signed [`SAMPLE_W-1:0] chan_zero_sample,
    output logic gate_open
);
    logic [31:0] trigger_or_mask_reg;
    logic [31:0] trigger_and_mask_reg;
    logic [31:0] main_ext_trigger_mode_reg;
    logic [31:0] chan_zero_trigger_mode_reg;
    logic [31:0] chan_zero_threshold_reg;
    logic [31:0] main_ext_threshold_reg;
    logic [31:0] chan_zero_pulse_count_reg;
    logic [31:0] pulse_count_next;
    logic [31:0] wmask;
    logic [31:0] rd_data;
    logic [15:0] idx;
    logic req;
    logic wr;
    logic main_gate;
    logic chan_gate;
    logic [31:0] src_gates;
    logic [31:0] and_sel;
    logic or_hit;
    logic and_hit;

    // ------------------------------------------------------------------
    // wishbone slave: one wait state, registered data
    // ------------------------------------------------------------------
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    // low two address bits are byte lanes inside the word
    assign idx = 16'(wb_adr_i[`ADR_W-1:2]);
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            trigger_or_mask_reg <= `RST_MASK;
            trigger_and_mask_reg <= `RST_MASK;
        end else if (wr) begin
            if (idx == `IDX_TRIGGER_OR_MASK) begin
                trigger_or_mask_reg <= (trigger_or_mask_reg & ~wmask) | (wb_dat_i & wmask);
            end
            if (idx == `IDX_TRIGGER_AND_MASK) begin
                trigger_and_mask_reg <= (trigger_and_mask_reg & ~wmask) | (wb_dat_i & wmask);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            main_ext_trigger_mode_reg <= `RST_MODE;
            chan_zero_trigger_mode_reg <= `RST_MODE;
        end else if (wr) begin
            if (idx == `IDX_MAIN_EXT_TRIGGER_MODE) begin
                main_ext_trigger_mode_reg <=
                    (main_ext_trigger_mode_reg & ~wmask) | (wb_dat_i & wmask);
            end
            if (idx == `IDX_CHAN_ZERO_TRIGGER_MODE) begin
                chan_zero_trigger_mode_reg <=
                    (chan_zero_trigger_mode_reg & ~wmask) | (wb_dat_i & wmask);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            main_ext_threshold_reg <= `RST_THRESHOLD;
            chan_zero_threshold_reg <= `RST_THRESHOLD;
        end else if (wr) begin
            if (idx == `IDX_MAIN_EXT_THRESHOLD) begin
                main_ext_threshold_reg <= (main_ext_threshold_reg & ~wmask) | (wb_dat_i & wmask);
            end
            if (idx == `IDX_CHAN_ZERO_THRESHOLD) begin
                chan_zero_threshold_reg <= (chan_zero_threshold_reg & ~wmask) | (wb_dat_i & wmask);
            end
        end
    end

    // a count below the minimum would open before any pulse exists,
    // so such a write is dropped and the old count stays
    assign pulse_count_next = (chan_zero_pulse_count_reg & ~wmask) | (wb_dat_i & wmask);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            chan_zero_pulse_count_reg <= `RST_PULSE_COUNT;
        end else if (wr && idx == `IDX_CHAN_ZERO_PULSE_COUNT &&
                     pulse_count_next >= `MIN_PULSE_COUNT) begin // [R18]
            chan_zero_pulse_count_reg <= pulse_count_next;
        end
    end

    always_comb begin
        unique case (idx)
            `IDX_TRIGGER_OR_MASK: rd_data = trigger_or_mask_reg;
            `IDX_TRIGGER_AND_MASK: rd_data = trigger_and_mask_reg;
            `IDX_MAIN_EXT_TRIGGER_MODE: rd_data = main_ext_trigger_mode_reg;
            `IDX_CHAN_ZERO_TRIGGER_MODE: rd_data = chan_zero_trigger_mode_reg;
            `IDX_CHAN_ZERO_THRESHOLD: rd_data = chan_zero_threshold_reg;
            `IDX_MAIN_EXT_THRESHOLD: rd_data = main_ext_threshold_reg;
            `IDX_CHAN_ZERO_PULSE_COUNT: rd_data = chan_zero_pulse_count_reg;
            `IDX_GATE_STATUS: rd_data = {28'h0, board_run, gate_open, main_gate, chan_gate};
            default: rd_data = 32'h0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wb_dat_o <= 32'h0;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= rd_data;
        end
    end

    // ------------------------------------------------------------------
    // the two trigger sources
    // ------------------------------------------------------------------
    // the pulse count register serves both inputs
    gate_source_detector u_main_ext (
        .ref_clk(ref_clk),
        .srst(srst),
        .board_run(board_run),
        .sample_en(sample_en),
        .sample(main_ext_sample),
        .mode(main_ext_trigger_mode_reg),
        .threshold(main_ext_threshold_reg),
        .pulse_count(chan_zero_pulse_count_reg),
        .gate(main_gate)
    );

    gate_source_detector u_chan_zero (
        .ref_clk(ref_clk),
        .srst(srst),
        .board_run(board_run),
        .sample_en(sample_en),
        .sample(chan_zero_sample),
        .mode(chan_zero_trigger_mode_reg),
        .threshold(chan_zero_threshold_reg),
        .pulse_count(chan_zero_pulse_count_reg),
        .gate(chan_gate)
    );

    // ------------------------------------------------------------------
    // mask combination
    // ------------------------------------------------------------------
    assign src_gates = ({32{main_gate}} & `MAIN_EXT_MASK_BIT) |
                       ({32{chan_gate}} & `CHAN_ZERO_MASK_BIT);
    assign and_sel = trigger_and_mask_reg & (`MAIN_EXT_MASK_BIT | `CHAN_ZERO_MASK_BIT);
    assign or_hit = |(trigger_or_mask_reg & src_gates); // [R1]
    // an empty and mask must not count as all sources present
    assign and_hit = (and_sel != 32'h0) && ((and_sel & src_gates) == and_sel); // [R1]

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            gate_open <= 1'b0;
        end else begin
            gate_open <= board_run && (or_hit || and_hit);
        end
    end

endmodule // analog_gate_trigger_detector

// file: test/gate_detect_checker.sv
// concurrent checks on the gate detector top ports
`timescale 1ns/1ps
module gate_detect_checker (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic board_run,
    input wire logic sample_en,
    input wire logic gate_open
);
    // ------------------------------------------------
    // bus handshake
    // ------------------------------------------------
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic req;
    assign req = wb_cyc_i && wb_stb_i;
    a_ack_prompt: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req))
        else $error("stray ack");
    a_reset_quiet: assert property ($fell(srst) |-> !wb_ack_o && !gate_open && wb_dat_o == 32'h0)
        else $error("reset left outputs");
    a_dat_holds: assert property (!$past(req && !wb_we_i && !wb_ack_o) |-> $stable(wb_dat_o))
        else $error("read data moved");
    // ------------------------------------------------
    // gate timing: a gate edge needs a sample, a write or a stop
    // ------------------------------------------------
    a_gate_needs_run: assert property (!board_run ##1 !board_run |-> !gate_open)
        else $error("gate open while stopped");
    a_open_cause: assert property ($rose(gate_open) |-> $past(board_run) &&
        ($past(sample_en, 2) || $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3)))
        else $error("gate opened without cause");
    a_close_cause: assert property ($fell(gate_open) |-> $past(sample_en, 2) ||
        !$past(board_run) || !$past(board_run, 2) || $past(wb_ack_o) || $past(wb_ack_o, 2)
        || $past(wb_ack_o, 3))
        else $error("gate closed without cause");
    c_gate_opens: cover property ($rose(gate_open));
    c_gate_closes: cover property ($fell(gate_open));
    c_read_done: cover property (wb_ack_o && !wb_we_i);
endmodule // gate_detect_checker

bind analog_gate_trigger_detector gate_detect_checker i_chk (.ref_clk, .srst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .board_run, .sample_en, .gate_open);

// file: test/analog_source_model.sv
// analog trigger source model: paced samples of two levels
`timescale 1ns/1ps
`include "gate_detect_params.svh"
module analog_source_model (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic signed [`SAMPLE_W-1:0] main_level,
    input wire logic signed [`SAMPLE_W-1:0] chan_level,
    output logic sample_en,
    output logic signed [`SAMPLE_W-1:0] main_ext_sample,
    output logic signed [`SAMPLE_W-1:0] chan_zero_sample
);
    logic [1:0] pace_reg;
    // free running like a converter, one sample every four clocks
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pace_reg <= 2'h0;
        end else begin
            pace_reg <= pace_reg + 2'h1;
        end
    end
    assign sample_en = (pace_reg == 2'h3);
    // off-strobe data is inverted so nothing leans on it
    assign main_ext_sample = sample_en ? main_level : ~main_level;
    assign chan_zero_sample = sample_en ? chan_level : ~chan_level;
endmodule // analog_source_model

// file: test/testbench.sv
// self-checking bench for the analog gate trigger detector
`timescale 1ns/1ps
`include "gate_detect_params.svh"
module testbench;
    logic ref_clk, srst, wb_cyc, wb_stb, wb_we, ack, board_run, sen, gate;
    logic [`ADR_W-1:0] wb_adr;
    logic [31:0] wb_wdat, rdat;
    logic signed [`SAMPLE_W-1:0] main_lvl, chan_lvl, main_s, chan_s;
    int err_total, cmp_count;
    logic [15:0] ridx [9];
    logic [31:0] rrst [9];
    localparam logic signed [15:0] HI = 16'sh0005;
    localparam logic signed [15:0] LO = -16'sh0005;

    analog_gate_trigger_detector i_dut (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
        .wb_dat_i(wb_wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .board_run(board_run),
        .sample_en(sen), .main_ext_sample(main_s), .chan_zero_sample(chan_s),
        .gate_open(gate));
    analog_source_model i_src (.ref_clk(ref_clk), .srst(srst), .main_level(main_lvl),
        .chan_level(chan_lvl), .sample_en(sen), .main_ext_sample(main_s),
        .chan_zero_sample(chan_s));

    // ------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------
    task automatic wb_xfer(input logic w, input logic [15:0] idx, input logic [31:0] d,
            output logic [31:0] q);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= {idx, 2'b00};
        wb_wdat <= d;
        do @(posedge ref_clk); while (ack !== 1'b1);
        q = rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] dmy;
        wb_xfer(1'b1, idx, d, dmy);
    endtask
    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        wb_xfer(1'b0, idx, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic chk_gate(input logic exp);
        chk({31'h0, gate}, {31'h0, exp});
    endtask
    // hold a level for n samples, then wait for the gate
    task automatic step(input logic signed [15:0] v, input int n = 1);
        main_lvl <= v;
        chan_lvl <= v;
        repeat (n) begin
            do @(posedge ref_clk); while (sen !== 1'b1);
        end
        repeat (3) @(posedge ref_clk);
    endtask
    // stop, program, restart; first sample primes, or opens a level mode whose level holds
    task automatic arm(input logic ch, input logic [31:0] md, input logic [31:0] thr,
            input logic signed [15:0] first);
        board_run <= 1'b0;
        wr(ch ? `IDX_CHAN_ZERO_TRIGGER_MODE : `IDX_MAIN_EXT_TRIGGER_MODE, md);
        wr(ch ? `IDX_CHAN_ZERO_THRESHOLD : `IDX_MAIN_EXT_THRESHOLD, thr);
        board_run <= 1'b1;
        step(first, 1);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------
    // clock, watchdog and test sequence
    // ------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        wrap_up();
    end
    initial begin
        srst = 1'b1;
        {wb_cyc, wb_stb, wb_we, board_run} = 4'h0;
        wb_adr = '0;
        wb_wdat = 32'h0;
        {main_lvl, chan_lvl} = 32'h0;
        err_total = 0;
        cmp_count = 0;
        ridx = '{`IDX_TRIGGER_OR_MASK, `IDX_TRIGGER_AND_MASK, `IDX_MAIN_EXT_TRIGGER_MODE,
            `IDX_CHAN_ZERO_TRIGGER_MODE, `IDX_CHAN_ZERO_THRESHOLD, `IDX_MAIN_EXT_THRESHOLD,
            `IDX_CHAN_ZERO_PULSE_COUNT, `IDX_GATE_STATUS, 16'h1234};
        rrst = '{`RST_MASK, `RST_MASK, `RST_MODE, `RST_MODE, `RST_THRESHOLD, `RST_THRESHOLD,
            `RST_PULSE_COUNT, 32'h0, 32'h0};
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        foreach (ridx[i]) rd_chk(ridx[i], rrst[i]);
        for (int i = 0; i < 7; i++) begin
            wr(ridx[i], 32'h5a5a_0002 + 32'(i));
            rd_chk(ridx[i], 32'h5a5a_0002 + 32'(i));
        end
        wr(16'h1234, 32'hffff_ffff);
        rd_chk(16'h1234, 32'h0);
        wr(`IDX_CHAN_ZERO_PULSE_COUNT, 32'h0000_0001);
        rd_chk(`IDX_CHAN_ZERO_PULSE_COUNT, 32'h5a5a_0008);
        wr(`IDX_CHAN_ZERO_PULSE_COUNT, 32'hffff_ffff);
        rd_chk(`IDX_CHAN_ZERO_PULSE_COUNT, 32'hffff_ffff);
        $display("test registers done");
        wr(`IDX_TRIGGER_OR_MASK, 32'h0);
        wr(`IDX_TRIGGER_AND_MASK, 32'h0);
        wr(`IDX_CHAN_ZERO_TRIGGER_MODE, 32'h0);
        arm(1'b0, `RISING_MODE_CODE, 32'h0, LO);
        step(HI);
        chk_gate(1'b0);
        wr(`IDX_TRIGGER_OR_MASK, `MAIN_EXT_MASK_BIT);
        arm(1'b0, `RISING_MODE_CODE, 32'h0, 16'sh0064);
        step(16'sh0064);
        chk_gate(1'b0);
        step(LO);
        step(HI);
        chk_gate(1'b1);
        rd_chk(`IDX_GATE_STATUS, 32'h0000_000e);
        step(-16'sh0001);
        chk_gate(1'b0);
        arm(1'b0, `FALLING_MODE_CODE, 32'h0, LO);
        step(LO);
        chk_gate(1'b0);
        step(HI);
        step(LO);
        chk_gate(1'b1);
        step(HI);
        chk_gate(1'b0);
        $display("test edge modes done");
        arm(1'b0, `ABOVE_LEVEL_MODE_CODE, 32'h0000_000a, 16'sh000a);
        chk_gate(1'b1);
        step(16'sh0009);
        chk_gate(1'b0);
        arm(1'b0, `BELOW_LEVEL_MODE_CODE, 32'h0000_000a, 16'sh000a);
        chk_gate(1'b1);
        step(16'sh000b);
        chk_gate(1'b0);
        $display("test level modes done");
        wr(`IDX_CHAN_ZERO_PULSE_COUNT, 32'h0000_0003);
        arm(1'b0, `LONG_RISING_PULSE_CODE, 32'h0, LO);
        step(HI, 2);
        chk_gate(1'b0);
        step(HI);
        chk_gate(1'b1);
        step(LO);
        chk_gate(1'b0);
        step(HI);
        step(LO, 3);
        chk_gate(1'b0);
        wr(`IDX_CHAN_ZERO_PULSE_COUNT, `MIN_PULSE_COUNT);
        arm(1'b0, `LONG_FALLING_PULSE_CODE, 32'h0, HI);
        step(LO, 2);
        chk_gate(1'b1);
        step(HI);
        chk_gate(1'b0);
        $display("test pulse modes done");
        wr(`IDX_TRIGGER_OR_MASK, 32'h0);
        wr(`IDX_TRIGGER_AND_MASK, `MAIN_EXT_MASK_BIT);
        arm(1'b0, `ABOVE_LEVEL_MODE_CODE, 32'h0, HI);
        chk_gate(1'b1);
        wr(`IDX_TRIGGER_AND_MASK, 32'h0);
        wr(`IDX_TRIGGER_OR_MASK, `CHAN_ZERO_MASK_BIT);
        wr(`IDX_MAIN_EXT_TRIGGER_MODE, 32'h0);
        arm(1'b1, `RISING_MODE_CODE, 32'h0, LO);
        step(HI);
        chk_gate(1'b1);
        step(LO);
        chk_gate(1'b0);
        arm(1'b1, `ABOVE_LEVEL_MODE_CODE, 32'h0, HI);
        chk_gate(1'b1);
        $display("test masks and second input done");
        wrap_up();
    end
endmodule // testbench
